// File: rtl/osrs_defs.svh
`ifndef OSRS_DEFS_SVH
`define OSRS_DEFS_SVH
// ----------------------------------------------------------------
// link commands
// ----------------------------------------------------------------
`define OSRS_CMD_PARAM_READ 8'h5a
`define OSRS_CMD_REG_READ 8'h65
`define OSRS_CMD_REG_WRITE 8'h71
`define OSRS_CMD_OTP_PROG 8'h42
`define OSRS_CMD_OTP_READ 8'h4b
`define OSRS_CMD_SOFT_RESET 8'hf0
// ----------------------------------------------------------------
// one-time-programmable space
// ----------------------------------------------------------------
`define OSRS_OTP_BYTES 1024
`define OSRS_OTP_TOP 24'h0003ff
`define OSRS_RAND_BYTES 16
`define OSRS_LOCK_BASE 10'h010
`define OSRS_ERASED 8'hff
`define OSRS_PARAM_BYTES 16
// ----------------------------------------------------------------
// register slots and fields
// ----------------------------------------------------------------
`define OSRS_SLOTS 21
`define OSRS_SLOT_STATUS1 0
`define OSRS_SLOT_CONFIG1 1
`define OSRS_SLOT_CONFIG2 2
`define OSRS_SLOT_TRAINING 5
`define OSRS_SLOT_STATUS2 6
`define OSRS_SLOT_CORRECTION 7
`define OSRS_SLOT_GUARD_OPT_LO 8
`define OSRS_SLOT_GUARD_OPT_HI 9
`define OSRS_SLOT_GUARD_LOCK 10
`define OSRS_SLOT_GUARD_ACCESS 11
`define OSRS_SLOT_DYN_ACCESS 12
`define OSRS_SLOT_PASSCODE 13
`define OSRS_REG_LIVE_BIT 7
`define OSRS_PERR_BIT 6
`define OSRS_FREEZE_BIT 0
`define OSRS_STATUS1_NV_MASK 8'h9c
`define OSRS_CONFIG1_NV_MASK 8'hfe
`define OSRS_FULL_MASK 8'hff
`define OSRS_NV_FACTORY 8'h00
`define OSRS_VOL_DEFAULT 8'h00
`define OSRS_UNMAPPED_READ 8'h00
`define OSRS_LINK_SAMPLE_BIT 3'h4
`endif

// File: rtl/osrs_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "osrs_defs.svh"
module osrs_link
  import osrs_pkg::*;
(
  input wire logic sck,
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic mosi,
  input wire osrs_tx_type tx,
  output var osrs_rx_type rx,
  output logic miso_o,
  output logic miso_oe
);
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_in_reg;
  logic [7:0] shift_out_reg;
  osrs_tx_type hold_reg;
  logic oe_reg;

  // frame position dies with chip select; sck may stop outside frames
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 7'h00;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_in_reg <= {shift_in_reg[5:0], mosi};
    end
  end

  // toggle marks each whole byte; data holds for the next 8 sck cycles
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
      rx <= '0;
    else if (bit_cnt_reg == 3'h7)
    begin
      rx.data <= {shift_in_reg, mosi};
      rx.tgl <= ~rx.tgl;
    end
  end

  // core word changes just after a byte starts, so sample it mid byte
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
      hold_reg <= '0;
    else if (bit_cnt_reg == `OSRS_LINK_SAMPLE_BIT)
      hold_reg <= tx;
  end

  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      shift_out_reg <= 8'h00;
      oe_reg <= 1'b0;
    end
    else if (bit_cnt_reg == 3'h0)
    begin
      shift_out_reg <= hold_reg.data;
      oe_reg <= hold_reg.en;
    end
    else
      shift_out_reg <= {shift_out_reg[6:0], 1'b0};
  end

  assign miso_o = shift_out_reg[7];
  assign miso_oe = oe_reg;
endmodule
`default_nettype wire

// File: rtl/osrs_otp_shadow.sv
`timescale 1ns/100ps
`default_nettype none
`include "osrs_defs.svh"
// Function
// - parameter read command returns a factory table; nothing can write it
// - one-time space of 1024 bytes, 32 lockable regions of 32 bytes
// - lowest 16 bytes hold factory random number; programming ones ignored
// - programming any zero into random bytes fails and sets error flag
// - four lock bytes after random number, erased, programmed to lock
// - byte 10h bit 0 locks region 0 up to byte 13h bit 7
// - twelve reserved bytes 014h-01Fh ship as FF and are programmable
// - regions 1 to 31 ship erased and accept user programming
// - lockout bit in live config1 bit 0 blocks programming until reset
// - registers are reached only by register commands, not memory space
// - register reads return the live copy
// - every reset type reloads live copies from stored copies
// - stored write replaces stored copy (status1, config1: nv mask bits only), then refreshes live copy
// - one-time register bits program stored copy, clear live bits alike
// - volatile write changes live copy only
// - volatile defaults after any reset; stored defaults are factory state
// - program failure flag is bit 6 of live status1
module osrs_otp_shadow
  import osrs_pkg::*;
#(
  // arbitrary values, stand-ins for factory content
  parameter logic [127:0] RAND_NUMBER = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210,
  parameter logic [127:0] PARAM_TABLE = 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hw_reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe
);
  osrs_rx_type rx;
  osrs_tx_type tx_reg;
  osrs_phase_type phase_reg;
  logic [7:0] cmd_reg;
  logic [1:0] acnt_reg;
  logic [23:0] ptr_reg;
  logic swrst_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic tg_s1_reg, tg_s2_reg, tg_s3_reg;
  logic hr_s1_reg, hr_s2_reg;
  logic byte_ev, frame_end, reload, is_read, addr_last;
  logic [23:0] addr_now, sel_addr;
  logic [4:0] slot;
  logic map_ok, live_sel, reg_we;
  logic [7:0] rd_data;
  logic [7:0] otp_mem [0:`OSRS_OTP_BYTES-1];
  logic [9:0] oaddr, lock_idx;
  logic [4:0] region;
  logic [7:0] lock_byte;
  logic prog_byte, in_space, in_rand, locked, frozen, prog_fail, otp_we;
  logic [7:0] live_w [0:`OSRS_SLOTS-1];
  logic [7:0] stored_w [0:`OSRS_SLOTS-1];

  // ----------------------------------------------------------------
  // serial link, own clock domain
  // ----------------------------------------------------------------
  osrs_link u_link (
    .sck(sck),
    .cs_n(cs_n),
    .rst_n(rst_n),
    .mosi(mosi),
    .tx(tx_reg),
    .rx(rx),
    .miso_o(miso_o),
    .miso_oe(miso_oe)
  );

  // ----------------------------------------------------------------
  // crossings into core_clk
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_s3_reg <= 1'b0;
      hr_s1_reg <= 1'b1;
      hr_s2_reg <= 1'b1;
    end
    else
    begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      tg_s1_reg <= rx.tgl;
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
      hr_s1_reg <= hw_reset_n;
      hr_s2_reg <= hr_s1_reg;
    end
  end

  // rx.data is stable for a whole byte after its toggle
  assign byte_ev = tg_s2_reg ^ tg_s3_reg;
  assign frame_end = cs_s2_reg & ~cs_s3_reg;
  assign reload = (frame_end & swrst_reg) | ~hr_s2_reg;

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  assign is_read = (cmd_reg == `OSRS_CMD_PARAM_READ) |
    (cmd_reg == `OSRS_CMD_REG_READ) | (cmd_reg == `OSRS_CMD_OTP_READ);
  assign addr_last = (phase_reg == OSRS_PH_ADDR) & (acnt_reg == 2'h2);
  assign addr_now = {ptr_reg[15:0], rx.data};
  assign sel_addr = (phase_reg == OSRS_PH_ADDR) ? addr_now : ptr_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || frame_end)
    begin
      phase_reg <= OSRS_PH_CMD;
      acnt_reg <= 2'h0;
    end
    else if (byte_ev)
    begin
      unique case (phase_reg)
        OSRS_PH_CMD:
        begin
          acnt_reg <= 2'h0;
          if (rx.data == `OSRS_CMD_PARAM_READ ||
              rx.data == `OSRS_CMD_REG_READ ||
              rx.data == `OSRS_CMD_REG_WRITE ||
              rx.data == `OSRS_CMD_OTP_PROG ||
              rx.data == `OSRS_CMD_OTP_READ)
            phase_reg <= OSRS_PH_ADDR;
          else
            phase_reg <= OSRS_PH_SKIP;
        end
        OSRS_PH_ADDR:
        begin
          acnt_reg <= acnt_reg + 2'h1;
          if (acnt_reg == 2'h2)
            phase_reg <= OSRS_PH_DATA;
        end
        OSRS_PH_DATA, OSRS_PH_SKIP:
          phase_reg <= phase_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cmd_reg <= 8'h00;
    else if (byte_ev && phase_reg == OSRS_PH_CMD)
      cmd_reg <= rx.data;
  end

  // soft reset acts when its frame closes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || frame_end)
      swrst_reg <= 1'b0;
    else if (byte_ev && phase_reg == OSRS_PH_CMD &&
             rx.data == `OSRS_CMD_SOFT_RESET)
      swrst_reg <= 1'b1;
  end

  // reads run one byte ahead: the dummy byte hides the crossing delay
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ptr_reg <= 24'h000000;
    else if (byte_ev && phase_reg == OSRS_PH_ADDR)
      ptr_reg <= addr_now + {23'h000000, addr_last & is_read};
    else if (byte_ev && phase_reg == OSRS_PH_DATA)
      ptr_reg <= ptr_reg + 24'h000001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || frame_end)
      tx_reg <= '0;
    else if (byte_ev && is_read && (addr_last || phase_reg == OSRS_PH_DATA))
    begin
      tx_reg.data <= rd_data;
      tx_reg.en <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read source
  // ----------------------------------------------------------------
  assign slot = sel_addr[4:0];
  assign live_sel = sel_addr[`OSRS_REG_LIVE_BIT];
  assign map_ok = (sel_addr[23:8] == 16'h0000) & (sel_addr[6:5] == 2'h0) &
    (slot < 5'(`OSRS_SLOTS));

  always_comb
  begin
    rd_data = `OSRS_UNMAPPED_READ;
    if (cmd_reg == `OSRS_CMD_PARAM_READ)
    begin
      // fixed table, no command writes it
      rd_data = `OSRS_ERASED;
      if (sel_addr < 24'(`OSRS_PARAM_BYTES))
        rd_data = PARAM_TABLE[{sel_addr[3:0], 3'h0} +: 8];
    end
    else if (cmd_reg == `OSRS_CMD_OTP_READ)
    begin
      rd_data = `OSRS_ERASED;
      if (sel_addr <= `OSRS_OTP_TOP)
        rd_data = otp_mem[sel_addr[9:0]];
    end
    else if (cmd_reg == `OSRS_CMD_REG_READ && map_ok)
      rd_data = live_w[slot];
  end

  // ----------------------------------------------------------------
  // one-time-programmable space
  // ----------------------------------------------------------------
  assign prog_byte = byte_ev & (phase_reg == OSRS_PH_DATA) &
    (cmd_reg == `OSRS_CMD_OTP_PROG);
  assign in_space = ptr_reg <= `OSRS_OTP_TOP;
  assign oaddr = ptr_reg[9:0];
  assign region = oaddr[9:5];
  assign lock_idx = `OSRS_LOCK_BASE + {8'h00, region[4:3]};
  assign lock_byte = otp_mem[lock_idx];
  assign locked = ~lock_byte[region[2:0]];
  assign in_rand = oaddr < 10'(`OSRS_RAND_BYTES);
  assign frozen = live_w[`OSRS_SLOT_CONFIG1][`OSRS_FREEZE_BIT];
  // checks hold for lock, reserved and user bytes alike
  assign prog_fail = prog_byte & (~in_space | frozen | locked |
    (in_rand & (rx.data != `OSRS_ERASED)));
  assign otp_we = prog_byte & ~prog_fail & ~in_rand;

  // cells only ever lose ones, as a real fuse would
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `OSRS_OTP_BYTES; i++)
        if (i < `OSRS_RAND_BYTES)
          otp_mem[i] <= RAND_NUMBER[8*i +: 8];
        else
          otp_mem[i] <= `OSRS_ERASED;
    end
    else if (otp_we)
      otp_mem[oaddr] <= otp_mem[oaddr] & rx.data;
  end

  // ----------------------------------------------------------------
  // shadowed registers
  // ----------------------------------------------------------------
  // register space is written only from the register write command
  assign reg_we = byte_ev & (phase_reg == OSRS_PH_DATA) &
    (cmd_reg == `OSRS_CMD_REG_WRITE) & map_ok;

  for (genvar i = 0; i < `OSRS_SLOTS; i++)
  begin : g_slot
    localparam osrs_kind_type KIND = osrs_slot_kind(i);
    localparam logic [7:0] MASK = osrs_nv_mask(i);
    localparam logic [7:0] ST_INIT = (KIND == OSRS_K_PAIR) ?
      `OSRS_NV_FACTORY : `OSRS_ERASED;
    localparam logic [7:0] LV_INIT = (KIND == OSRS_K_VOL ||
      KIND == OSRS_K_RO) ? `OSRS_VOL_DEFAULT : ST_INIT;
    logic [7:0] st_reg, st_next, lv_reg, lv_next;
    logic hit;

    assign hit = reg_we & (slot == 5'(i));

    always_comb
    begin
      st_next = st_reg;
      lv_next = lv_reg;
      if (reload)
        lv_next = (KIND == OSRS_K_VOL || KIND == OSRS_K_RO) ?
          `OSRS_VOL_DEFAULT : st_reg;
      else if (hit)
      begin
        if (KIND == OSRS_K_PAIR && live_sel)
          lv_next = rx.data;
        else if (KIND == OSRS_K_PAIR)
        begin
          st_next = (rx.data & MASK) | (st_reg & ~MASK);
          lv_next = st_next;
        end
        else if (KIND == OSRS_K_VOL)
          lv_next = rx.data;
        else if (KIND == OSRS_K_NV)
        begin
          st_next = rx.data;
          lv_next = rx.data;
        end
        else if (KIND == OSRS_K_OTP)
        begin
          st_next = st_reg & rx.data;
          lv_next = lv_reg & rx.data;
        end
      end
      // lockout cannot be cleared by software, only by a reset
      if (i == `OSRS_SLOT_CONFIG1 && lv_reg[`OSRS_FREEZE_BIT] && !reload)
        lv_next[`OSRS_FREEZE_BIT] = 1'b1;
      // failure set wins over any same-cycle write or reload
      if (i == `OSRS_SLOT_STATUS1 && prog_fail)
        lv_next[`OSRS_PERR_BIT] = 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        st_reg <= ST_INIT;
        lv_reg <= LV_INIT;
      end
      else
      begin
        st_reg <= st_next;
        lv_reg <= lv_next;
      end
    end

    assign stored_w[i] = st_reg;
    assign live_w[i] = lv_reg;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_freeze_no_prog: assert property (
    frozen |-> !otp_we)
    else $error("one-time space written while locked out");
  a_freeze_sticky: assert property (
    frozen && !reload |=> frozen)
    else $error("lockout bit cleared without reset");
  a_fail_sets_flag: assert property (
    prog_fail |=> live_w[`OSRS_SLOT_STATUS1][`OSRS_PERR_BIT])
    else $error("failed program did not set error flag");
  a_rand_untouched: assert property (
    prog_byte && in_rand |-> !otp_we)
    else $error("random number byte was written");
  a_rand_zero_fails: assert property (
    prog_byte && in_rand && rx.data != 8'hff |-> prog_fail)
    else $error("zero into random number did not fail");
  a_lock_respected: assert property (
    prog_byte && locked |-> prog_fail && !otp_we)
    else $error("locked region accepted programming");
  a_reload_copies: assert property (
    reload |=> live_w[`OSRS_SLOT_CONFIG2] ==
      $past(stored_w[`OSRS_SLOT_CONFIG2]))
    else $error("live copy not reloaded from stored copy");
  a_vol_keeps_nv: assert property (
    reg_we && slot == 5'(`OSRS_SLOT_CONFIG2) && live_sel && !reload
      |=> $stable(stored_w[`OSRS_SLOT_CONFIG2]) &&
      live_w[`OSRS_SLOT_CONFIG2] == $past(rx.data))
    else $error("volatile write disturbed stored copy");
  a_nv_refresh: assert property (
    reg_we && slot == 5'(`OSRS_SLOT_CONFIG2) && !live_sel && !reload
      |=> live_w[`OSRS_SLOT_CONFIG2] == stored_w[`OSRS_SLOT_CONFIG2] &&
      stored_w[`OSRS_SLOT_CONFIG2] == $past(rx.data))
    else $error("stored write did not refresh live copy");
  a_read_live: assert property (
    byte_ev && (addr_last || phase_reg == OSRS_PH_DATA) && is_read &&
      cmd_reg == `OSRS_CMD_REG_READ && map_ok &&
      slot == 5'(`OSRS_SLOT_CONFIG2) && !frame_end
      |=> tx_reg.data == $past(live_w[`OSRS_SLOT_CONFIG2]))
    else $error("register read did not return live copy");

  c_otp_write: cover property (otp_we);
  c_prog_fail: cover property (prog_fail ##1 reload);
  c_reg_write: cover property (reg_we ##[1:200] reload);
  c_read_data: cover property ($rose(tx_reg.en) && cmd_reg ==
    `OSRS_CMD_OTP_READ);
endmodule
`default_nettype wire

// File: rtl/osrs_pkg.sv
`include "osrs_defs.svh"
package osrs_pkg;
  typedef enum logic [2:0] {
    OSRS_K_PAIR = 3'b000,
    OSRS_K_VOL = 3'b001,
    OSRS_K_NV = 3'b010,
    OSRS_K_OTP = 3'b011,
    OSRS_K_RO = 3'b100
  } osrs_kind_type;
  typedef enum logic [1:0] {
    OSRS_PH_CMD = 2'b00,
    OSRS_PH_ADDR = 2'b01,
    OSRS_PH_DATA = 2'b10,
    OSRS_PH_SKIP = 2'b11
  } osrs_phase_type;
  typedef struct packed {logic tgl; logic [7:0] data;} osrs_rx_type;
  typedef struct packed {logic en; logic [7:0] data;} osrs_tx_type;
  function automatic osrs_kind_type osrs_slot_kind(input int idx);
    if (idx <= `OSRS_SLOT_TRAINING) return OSRS_K_PAIR;
    if (idx == `OSRS_SLOT_CORRECTION) return OSRS_K_RO;
    if (idx == `OSRS_SLOT_GUARD_OPT_LO || idx == `OSRS_SLOT_GUARD_OPT_HI)
      return OSRS_K_OTP;
    if (idx == `OSRS_SLOT_GUARD_ACCESS || idx >= `OSRS_SLOT_PASSCODE)
      return OSRS_K_NV;
    return OSRS_K_VOL;
  endfunction
  function automatic logic [7:0] osrs_nv_mask(input int idx);
    if (idx == `OSRS_SLOT_STATUS1) return `OSRS_STATUS1_NV_MASK;
    if (idx == `OSRS_SLOT_CONFIG1) return `OSRS_CONFIG1_NV_MASK;
    return `OSRS_FULL_MASK;
  endfunction
endpackage

// File: verification/osrs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// host side of the serial link, mode 0, clock only within frames
// ----------------------------------------------------------------
module osrs_host_model (
  output var logic sck,
  output var logic cs_n,
  output var logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic last_bit;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    last_bit = 1'b0;
  end
  // odd offset keeps frames out of step with the core clock
  task automatic open_frame;
    #13;
    cs_n = 1'b0;
    #40;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      #80;
      sck = 1'b1;
      // undriven line has no pull: show the inverse of its last level
      last_bit = miso_oe ? miso_o : ~last_bit;
      rx[i] = last_bit;
      #80;
      sck = 1'b0;
    end
  endtask
  // gap of ten core cycles lets the core finish the last byte
  task automatic close_frame;
    #40;
    cs_n = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "osrs_defs.svh"
module testbench;
  // arbitrary factory content
  localparam logic [127:0] RND = 128'h5a3c_9e17_0b62_d4f8_2e91_c7a0_6b3d_84f5;
  localparam logic [127:0] PRM = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_f001;
  localparam logic [7:0] PRG = `OSRS_CMD_OTP_PROG;
  localparam logic [7:0] ORD = `OSRS_CMD_OTP_READ;
  localparam logic [7:0] RRD = `OSRS_CMD_REG_READ;
  localparam logic [7:0] RWR = `OSRS_CMD_REG_WRITE;
  localparam logic [23:0] ST = 24'h000080;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_reset_n = 1'b1;
  wire logic sck;
  wire logic cs_n;
  wire logic mosi;
  wire logic miso_o;
  wire logic miso_oe;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  osrs_otp_shadow #(.RAND_NUMBER(RND), .PARAM_TABLE(PRM)) i_osrs_otp_shadow (
    .core_clk(core_clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));
  osrs_host_model i_osrs_host_model (.sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      $display("[FAIL] run length expected below 80000 seen %0d", cycles);
      results();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // every register or space is reached only by its own command
  task automatic cmd_addr(input logic [7:0] c, input logic [23:0] a);
    logic [7:0] d;
    i_osrs_host_model.open_frame();
    i_osrs_host_model.xfer(c, d);
    i_osrs_host_model.xfer(a[23:16], d);
    i_osrs_host_model.xfer(a[15:8], d);
    i_osrs_host_model.xfer(a[7:0], d);
  endtask
  task automatic wr(input logic [7:0] c, input logic [23:0] a,
                    input logic [7:0] v);
    logic [7:0] d;
    cmd_addr(c, a);
    i_osrs_host_model.xfer(v, d);
    i_osrs_host_model.close_frame();
  endtask
  // burst read after one dummy byte, address counting up
  task automatic burst(input logic [7:0] c, input logic [23:0] a,
                       input int n, input logic [127:0] exp, input string w);
    logic [7:0] d;
    cmd_addr(c, a);
    i_osrs_host_model.xfer(8'h00, d);
    for (int i = 0; i < n; i++)
    begin
      i_osrs_host_model.xfer(8'h00, d);
      chk(w, exp[8*i+:8], d);
    end
    i_osrs_host_model.close_frame();
  endtask
  task automatic rd(input logic [7:0] c, input logic [23:0] a,
                    input logic [7:0] exp, input string w);
    burst(c, a, 1, {120'h0, exp}, w);
  endtask
  task automatic clear_status;
    wr(RWR, ST, 8'h00);
    rd(RRD, ST, 8'h00, "status1 live cleared");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_param;
    burst(`OSRS_CMD_PARAM_READ, 24'h0, 16, PRM, "param table");
    rd(`OSRS_CMD_PARAM_READ, 24'h10, 8'hff, "param above");
    $display("test param done");
  endtask
  task automatic t_random;
    burst(ORD, 24'h0, 16, RND, "random number");
    wr(PRG, 24'h3, 8'hff);
    rd(ORD, 24'h3, RND[31:24], "random ones");
    rd(RRD, ST, 8'h00, "status1 after ones");
    wr(PRG, 24'h5, 8'hfe);
    rd(ORD, 24'h5, RND[47:40], "random zero");
    rd(RRD, ST, 8'h40, "status1 after zero");
    clear_status();
    $display("test random done");
  endtask
  task automatic t_ship;
    burst(ORD, 24'h10, 16, {128{1'b1}}, "lock and spare");
    rd(ORD, 24'h20, 8'hff, "region1 first");
    rd(ORD, 24'h3ff, 8'hff, "region31 last");
    wr(PRG, 24'h15, 8'h5a);
    rd(ORD, 24'h15, 8'h5a, "spare byte");
    wr(PRG, 24'h25, 8'haa);
    wr(PRG, 24'h25, 8'h0f);
    rd(ORD, 24'h25, 8'h0a, "user byte");
    rd(RRD, ST, 8'h00, "status1 user ok");
    wr(PRG, 24'h400, 8'h00);
    rd(RRD, ST, 8'h40, "status1 beyond space");
    rd(ORD, 24'h400, 8'hff, "beyond space");
    clear_status();
    $display("test ship done");
  endtask
  task automatic t_lock;
    wr(PRG, 24'h10, 8'hfd);
    rd(ORD, 24'h10, 8'hfd, "lock byte0");
    wr(PRG, 24'h30, 8'h00);
    rd(ORD, 24'h30, 8'hff, "locked region1");
    rd(RRD, ST, 8'h40, "status1 locked");
    clear_status();
    wr(PRG, 24'h40, 8'h00);
    rd(ORD, 24'h40, 8'h00, "open region2");
    wr(PRG, 24'h13, 8'h7f);
    wr(PRG, 24'h3e0, 8'h00);
    rd(ORD, 24'h3e0, 8'hff, "locked region31");
    clear_status();
    $display("test lock done");
  endtask
  task automatic t_freeze;
    logic [7:0] d;
    wr(RWR, 24'h81, 8'h01);
    wr(PRG, 24'h41, 8'h00);
    rd(ORD, 24'h41, 8'hff, "frozen space");
    rd(RRD, ST, 8'h40, "status1 frozen");
    i_osrs_host_model.open_frame();
    i_osrs_host_model.xfer(`OSRS_CMD_SOFT_RESET, d);
    i_osrs_host_model.close_frame();
    rd(RRD, 24'h81, 8'h00, "config1 live");
    rd(RRD, ST, 8'h00, "status1 reloaded");
    wr(PRG, 24'h41, 8'h00);
    rd(ORD, 24'h41, 8'h00, "thawed space");
    $display("test freeze done");
  endtask
  task automatic t_regs;
    wr(RWR, 24'h02, 8'h3c);
    rd(RRD, 24'h82, 8'h3c, "config2 live");
    wr(RWR, 24'h82, 8'h99);
    rd(RRD, 24'h82, 8'h99, "config2 live write");
    wr(RWR, 24'h83, 8'h55);
    rd(RRD, 24'h83, 8'h55, "config3 live");
    wr(RWR, 24'h86, 8'ha5);
    rd(RRD, 24'h86, 8'ha5, "status2 live");
    wr(RWR, 24'h88, 8'hf0);
    wr(RWR, 24'h88, 8'h3c);
    rd(RRD, 24'h88, 8'h30, "guard options");
    @(negedge core_clk) hw_reset_n = 1'b0;
    repeat (10) @(negedge core_clk);
    hw_reset_n = 1'b1;
    repeat (6) @(negedge core_clk);
    rd(RRD, 24'h82, 8'h3c, "config2 reload");
    rd(RRD, 24'h83, 8'h00, "config3 reload");
    rd(RRD, 24'h86, 8'h00, "status2 default");
    rd(RRD, 24'h88, 8'h30, "guard options kept");
    rd(RRD, 24'h87, 8'h00, "correction status");
    wr(RWR, 24'h95, 8'h77);
    rd(RRD, 24'h95, 8'h00, "unmapped slot");
    rd(RRD, 24'h182, 8'h00, "high address");
    $display("test regs done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    t_param();
    t_random();
    t_ship();
    t_lock();
    t_freeze();
    t_regs();
    results();
  end
endmodule
`default_nettype wire
